// >>> ufsc_map.svh
// Register indexes, field positions, reset values and timing figures
`ifndef UFSC_MAP_SVH
`define UFSC_MAP_SVH
`define UFSC_IDX_RSVD_A 8'h14
`define UFSC_IDX_P1_SHADOW 8'h15
`define UFSC_IDX_P2_SHADOW 8'h16
`define UFSC_IDX_RSVD_B 8'h17
`define UFSC_IDX_MISC 8'h18
`define UFSC_RSVD_A_VAL 8'h00
`define UFSC_RSVD_B_VAL 8'h03
`define UFSC_MISC_RST 8'h00
`define UFSC_MISC_WMASK 8'hF0
`define UFSC_MISC_HARD_KEEP 8'h3F
`define UFSC_FCR_WMASK 8'hCF
`define UFSC_FCR_SELFCLR 8'hF9
`define UFSC_BIT_FIFO_EN 0
`define UFSC_BIT_RX_FLUSH 1
`define UFSC_BIT_TX_FLUSH 2
`define UFSC_BIT_DMA 3
`define UFSC_BIT_THR_LO 6
`define UFSC_BIT_MUSIC_LO 4
`define UFSC_BIT_SPEED_LO 6
`define UFSC_THR_1 4'h1
`define UFSC_THR_4 4'h4
`define UFSC_THR_8 4'h8
`define UFSC_THR_14 4'hE
`define UFSC_CLK_HZ 100000000
`define UFSC_MUSIC_BAUD 31250
`define UFSC_OVERSAMPLE 16
`endif

// >>> ufsc_pkg.sv
// Types shared by the configuration shadow block
package ufsc_pkg;
    typedef logic [7:0] ufsc_byte_t;
    typedef enum logic [1:0] {
        UFSC_THR_ONE = 2'b00,
        UFSC_THR_FOUR = 2'b01,
        UFSC_THR_EIGHT = 2'b10,
        UFSC_THR_FOURTEEN = 2'b11
    } ufsc_thr_t;
endpackage

// >>> ufsc_fcr_shadow.sv
// Shadow copy of one port's write-only FIFO control register
`timescale 1ns/100ps
`include "ufsc_map.svh"
module ufsc_fcr_shadow (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic fcr_wr,
    input wire ufsc_pkg::ufsc_byte_t fcr_wdata,
    output ufsc_pkg::ufsc_byte_t shadow,
    output logic fifo_en,
    output logic rx_queue_flush,
    output logic tx_queue_flush,
    output logic dma_mode,
    output ufsc_pkg::ufsc_thr_t rx_threshold
);
    import ufsc_pkg::*;

    ufsc_byte_t shadow_q;

    // Flush bits live one cycle, then self-clear
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            shadow_q <= 8'h00;
        end else if (fcr_wr) begin
            shadow_q <= fcr_wdata & `UFSC_FCR_WMASK;
        end else begin
            shadow_q <= shadow_q & `UFSC_FCR_SELFCLR;
        end
    end

    assign shadow = shadow_q;
    assign fifo_en = shadow_q[`UFSC_BIT_FIFO_EN];
    assign rx_queue_flush = shadow_q[`UFSC_BIT_RX_FLUSH];
    assign tx_queue_flush = shadow_q[`UFSC_BIT_TX_FLUSH];
    // Stored for readback only; nothing in the port acts on it
    assign dma_mode = shadow_q[`UFSC_BIT_DMA];
    assign rx_threshold = ufsc_thr_t'(shadow_q[`UFSC_BIT_THR_LO +: 2]);

    a_flush_selfclr: assert property (@(posedge ref_clk) disable iff (rst)
        (rx_queue_flush || tx_queue_flush) && !fcr_wr |=> !rx_queue_flush && !tx_queue_flush)
        else $error("flush bit did not self-clear");
    a_shadow_follows: assert property (@(posedge ref_clk) disable iff (rst)
        fcr_wr |=> (shadow_q == (($past(fcr_wdata)) & `UFSC_FCR_WMASK)))
        else $error("shadow does not hold written value");
endmodule

// >>> ufsc_cfg_regs.sv
// Configuration registers: two FIFO control shadows, reserved slots, ports 3/4 control
`timescale 1ns/100ps
`include "ufsc_map.svh"
module ufsc_cfg_regs #(
    parameter int NUM_SHADOW = 2,
    parameter int CLK_HZ = `UFSC_CLK_HZ
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic hard_rst_pin,
    input wire logic cfg_state,
    input wire logic index_wr,
    input wire ufsc_pkg::ufsc_byte_t index_wdata,
    input wire logic data_wr,
    input wire logic data_rd,
    input wire ufsc_pkg::ufsc_byte_t data_wdata,
    output ufsc_pkg::ufsc_byte_t data_rdata,
    output logic data_hit,
    output ufsc_pkg::ufsc_byte_t config_index_reg,
    input wire logic [NUM_SHADOW-1:0] fcr_wr,
    input wire ufsc_pkg::ufsc_byte_t fcr_wdata,
    output logic [NUM_SHADOW-1:0] fifo_en,
    output logic [NUM_SHADOW-1:0] rx_queue_flush,
    output logic [NUM_SHADOW-1:0] tx_queue_flush,
    output logic [NUM_SHADOW-1:0] dma_mode,
    output logic [NUM_SHADOW*4-1:0] rx_threshold_bytes,
    output logic port3_music_clock_sel,
    output logic port4_music_clock_sel,
    output logic port3_high_speed,
    output logic port4_high_speed,
    output logic [1:0] music_baud16_tick
);
    import ufsc_pkg::*;

    localparam int MUSIC_DIV = CLK_HZ / (`UFSC_MUSIC_BAUD * `UFSC_OVERSAMPLE);
    localparam int DIV_W = $clog2(MUSIC_DIV + 1);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(MUSIC_DIV - 1);
    localparam logic [DIV_W-1:0] GAP_FIRST = DIV_W'(MUSIC_DIV);

    ufsc_byte_t index_q;
    ufsc_byte_t misc_q;
    ufsc_byte_t rdata_q;
    logic hit_q;
    logic hard_meta_q;
    logic hard_sync_q;
    ufsc_byte_t shadow [NUM_SHADOW];
    ufsc_thr_t thr [NUM_SHADOW];
    logic idx_ok;
    logic misc_wr;
    ufsc_byte_t rd_mux;

    // Hard reset comes from a pin, so two flops before use
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            hard_meta_q <= 1'b0;
            hard_sync_q <= 1'b0;
        end else begin
            hard_meta_q <= hard_rst_pin;
            hard_sync_q <= hard_meta_q;
        end
    end

    // Index is only loaded while the port is in configuration state
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            index_q <= 8'h00;
        end else if (cfg_state && index_wr) begin
            index_q <= index_wdata;
        end
    end
    assign config_index_reg = index_q;

    generate
        for (genvar p = 0; p < NUM_SHADOW; p++) begin : g_shadow
            ufsc_fcr_shadow u_shadow (
                .ref_clk(ref_clk),
                .rst(rst),
                .fcr_wr(fcr_wr[p]),
                .fcr_wdata(fcr_wdata),
                .shadow(shadow[p]),
                .fifo_en(fifo_en[p]),
                .rx_queue_flush(rx_queue_flush[p]),
                .tx_queue_flush(tx_queue_flush[p]),
                .dma_mode(dma_mode[p]),
                .rx_threshold(thr[p])
            );
            always_comb begin
                case (thr[p])
                    UFSC_THR_ONE: rx_threshold_bytes[p*4 +: 4] = `UFSC_THR_1;
                    UFSC_THR_FOUR: rx_threshold_bytes[p*4 +: 4] = `UFSC_THR_4;
                    UFSC_THR_EIGHT: rx_threshold_bytes[p*4 +: 4] = `UFSC_THR_8;
                    UFSC_THR_FOURTEEN: rx_threshold_bytes[p*4 +: 4] = `UFSC_THR_14;
                    default: rx_threshold_bytes[p*4 +: 4] = `UFSC_THR_1;
                endcase
            end

            a_shadow_write: assert property (@(posedge ref_clk) disable iff (rst)
                fcr_wr[p] |=> shadow[p] == ($past(fcr_wdata) & `UFSC_FCR_WMASK))
                else $error("shadow missed a control write");
            a_shadow_hold: assert property (@(posedge ref_clk) disable iff (rst)
                !fcr_wr[p] |=> shadow[p] == ($past(shadow[p]) & `UFSC_FCR_SELFCLR))
                else $error("shadow changed without a control write");
            a_enable_follows: assert property (@(posedge ref_clk) disable iff (rst)
                fcr_wr[p] |=> fifo_en[p] == $past(fcr_wdata[`UFSC_BIT_FIFO_EN]))
                else $error("queue enable does not follow its bit");
            a_rx_flush: assert property (@(posedge ref_clk) disable iff (rst)
                fcr_wr[p] |=> rx_queue_flush[p] == $past(fcr_wdata[`UFSC_BIT_RX_FLUSH]))
                else $error("receive flush does not follow its bit");
            a_tx_flush: assert property (@(posedge ref_clk) disable iff (rst)
                fcr_wr[p] |=> tx_queue_flush[p] == $past(fcr_wdata[`UFSC_BIT_TX_FLUSH]))
                else $error("transmit flush does not follow its bit");
            a_dma_kept: assert property (@(posedge ref_clk) disable iff (rst)
                fcr_wr[p] |=> dma_mode[p] == $past(fcr_wdata[`UFSC_BIT_DMA]))
                else $error("DMA select not stored");
            a_shadow_rsvd: assert property (@(posedge ref_clk) disable iff (rst)
                (shadow[p] & ~`UFSC_FCR_WMASK) == 8'h00)
                else $error("shadow reserved bits set");
            a_thr_map: assert property (@(posedge ref_clk) disable iff (rst)
                rx_threshold_bytes[p*4 +: 4] == (shadow[p][`UFSC_BIT_THR_LO + 1]
                ? (shadow[p][`UFSC_BIT_THR_LO] ? `UFSC_THR_14 : `UFSC_THR_8)
                : (shadow[p][`UFSC_BIT_THR_LO] ? `UFSC_THR_4 : `UFSC_THR_1)))
                else $error("threshold decode wrong");
            a_thr_keep: assert property (@(posedge ref_clk) disable iff (rst)
                !fcr_wr[p] |=> $stable(rx_threshold_bytes[p*4 +: 4]))
                else $error("threshold moved without a write");
        end
    endgenerate

    assign idx_ok = cfg_state;
    assign misc_wr = idx_ok && data_wr && (index_q == `UFSC_IDX_MISC);

    // Only the upper nibble is writable; hard reset drops the speed bits
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            misc_q <= `UFSC_MISC_RST;
        end else if (hard_sync_q) begin
            misc_q <= misc_q & `UFSC_MISC_HARD_KEEP;
        end else if (misc_wr) begin
            misc_q <= data_wdata & `UFSC_MISC_WMASK;
        end
    end

    assign port3_music_clock_sel = misc_q[`UFSC_BIT_MUSIC_LO];
    assign port4_music_clock_sel = misc_q[`UFSC_BIT_MUSIC_LO + 1];
    assign port3_high_speed = misc_q[`UFSC_BIT_SPEED_LO];
    assign port4_high_speed = misc_q[`UFSC_BIT_SPEED_LO + 1];

    // Divider is exact at 100 MHz; other clocks may miss the 1% window
    generate
        for (genvar m = 0; m < 2; m++) begin : g_music
            logic [DIV_W-1:0] div_q;
            logic tick_q;
            always_ff @(posedge ref_clk or posedge rst) begin
                if (rst) begin
                    div_q <= '0;
                    tick_q <= 1'b0;
                end else if (!misc_q[`UFSC_BIT_MUSIC_LO + m]) begin
                    div_q <= '0;
                    tick_q <= 1'b0;
                end else if (div_q == DIV_LAST) begin
                    div_q <= '0;
                    tick_q <= 1'b1;
                end else begin
                    div_q <= div_q + 1'b1;
                    tick_q <= 1'b0;
                end
            end
            assign music_baud16_tick[m] = tick_q;
        end
    endgenerate

    // Read decode; reserved slot A has no storage, so it reads a fixed value
    always_comb begin
        case (index_q)
            `UFSC_IDX_RSVD_A: rd_mux = `UFSC_RSVD_A_VAL;
            `UFSC_IDX_P1_SHADOW: rd_mux = shadow[0];
            `UFSC_IDX_P2_SHADOW: rd_mux = shadow[NUM_SHADOW-1];
            `UFSC_IDX_RSVD_B: rd_mux = `UFSC_RSVD_B_VAL;
            `UFSC_IDX_MISC: rd_mux = misc_q;
            default: rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rdata_q <= 8'h00;
            hit_q <= 1'b0;
        end else if (idx_ok && data_rd) begin
            rdata_q <= rd_mux;
            hit_q <= (index_q >= `UFSC_IDX_RSVD_A) && (index_q <= `UFSC_IDX_MISC);
        end else begin
            hit_q <= 1'b0;
        end
    end
    assign data_rdata = rdata_q;
    assign data_hit = hit_q;

    a_misc_low_zero: assert property (@(posedge ref_clk) disable iff (rst)
        misc_q[3:0] == 4'h0)
        else $error("misc reserved bits not zero");
    a_hard_rst_speed: assert property (@(posedge ref_clk) disable iff (rst)
        hard_rst_pin ##1 hard_rst_pin |=> ##1 (misc_q[7:6] == 2'b00))
        else $error("speed bits survived hard reset");
    a_hard_keep_music: assert property (@(posedge ref_clk) disable iff (rst)
        hard_sync_q |=> misc_q[5:4] == $past(misc_q[5:4]))
        else $error("hard reset touched music bits");
    a_rsvd_b_read: assert property (@(posedge ref_clk) disable iff (rst)
        cfg_state && data_rd && index_q == `UFSC_IDX_RSVD_B |=> data_rdata == 8'h03)
        else $error("reserved slot B did not read 03");
    a_no_read_outside: assert property (@(posedge ref_clk) disable iff (rst)
        !cfg_state |=> !data_hit && $stable(data_rdata))
        else $error("read served outside config state");
    a_idx_hold: assert property (@(posedge ref_clk) disable iff (rst)
        !cfg_state |=> $stable(index_q))
        else $error("index changed outside config state");
    a_p1_shadow_rd: assert property (@(posedge ref_clk) disable iff (rst)
        cfg_state && data_rd && index_q == `UFSC_IDX_P1_SHADOW |=> data_rdata[5:4] == 2'b00)
        else $error("shadow reserved bits not zero");
    a_shadow_ro: assert property (@(posedge ref_clk) disable iff (rst)
        data_wr && !(|fcr_wr) && !fifo_en[0] |=> !fifo_en[0])
        else $error("config write changed shadow");
    a_music_period: assert property (@(posedge ref_clk) disable iff (rst)
        music_baud16_tick[0] && port3_music_clock_sel ##1 port3_music_clock_sel [*8]
        |-> !music_baud16_tick[0])
        else $error("music tick too frequent");
    a_music_off: assert property (@(posedge ref_clk) disable iff (rst)
        !port3_music_clock_sel |=> !music_baud16_tick[0])
        else $error("music tick while disabled");

    a_idx_load: assert property (@(posedge ref_clk) disable iff (rst)
        cfg_state && index_wr |=> config_index_reg == $past(index_wdata))
        else $error("index not loaded");
    a_misc_write: assert property (@(posedge ref_clk) disable iff (rst)
        cfg_state && data_wr && index_q == `UFSC_IDX_MISC && !hard_sync_q
        |=> misc_q == ($past(data_wdata) & `UFSC_MISC_WMASK))
        else $error("misc write did not land");
    a_misc_guard: assert property (@(posedge ref_clk) disable iff (rst)
        !(cfg_state && data_wr && index_q == `UFSC_IDX_MISC) && !hard_sync_q |=> $stable(misc_q))
        else $error("misc changed without its write");
    a_music_set: assert property (@(posedge ref_clk) disable iff (rst)
        cfg_state && data_wr && index_q == `UFSC_IDX_MISC && !hard_sync_q
        |=> {port4_music_clock_sel, port3_music_clock_sel} == $past(data_wdata[`UFSC_BIT_MUSIC_LO +: 2]))
        else $error("music select not written");
    a_speed_set: assert property (@(posedge ref_clk) disable iff (rst)
        cfg_state && data_wr && index_q == `UFSC_IDX_MISC && !hard_sync_q
        |=> {port4_high_speed, port3_high_speed} == $past(data_wdata[`UFSC_BIT_SPEED_LO +: 2]))
        else $error("speed select not written");
    a_hard_wins: assert property (@(posedge ref_clk) disable iff (rst)
        hard_sync_q |=> {port4_high_speed, port3_high_speed} == 2'b00)
        else $error("speed bits kept during hard reset");

    a_rsvd_a_hit: assert property (@(posedge ref_clk) disable iff (rst)
        cfg_state && data_rd && index_q == `UFSC_IDX_RSVD_A |=> data_hit && data_rdata == `UFSC_RSVD_A_VAL)
        else $error("reserved slot A read wrong");
    a_p1_read: assert property (@(posedge ref_clk) disable iff (rst)
        cfg_state && data_rd && index_q == `UFSC_IDX_P1_SHADOW |=> data_hit && data_rdata == $past(shadow[0]))
        else $error("port one shadow read wrong");
    a_p2_read: assert property (@(posedge ref_clk) disable iff (rst)
        cfg_state && data_rd && index_q == `UFSC_IDX_P2_SHADOW |=> data_hit && data_rdata == $past(shadow[1]))
        else $error("port two shadow read wrong");
    a_misc_read: assert property (@(posedge ref_clk) disable iff (rst)
        cfg_state && data_rd && index_q == `UFSC_IDX_MISC |=> data_hit && data_rdata == $past(misc_q))
        else $error("misc read wrong");
    a_miss_read: assert property (@(posedge ref_clk) disable iff (rst)
        cfg_state && data_rd && (index_q < `UFSC_IDX_RSVD_A || index_q > `UFSC_IDX_MISC)
        |=> !data_hit && data_rdata == 8'h00)
        else $error("unknown index answered");
    a_rdata_hold: assert property (@(posedge ref_clk) disable iff (rst)
        !(cfg_state && data_rd) |=> !data_hit && $stable(data_rdata))
        else $error("read data moved without a read");
    a_hit_source: assert property (@(posedge ref_clk) disable iff (rst)
        data_hit |-> $past(cfg_state && data_rd))
        else $error("hit without an accepted read");
    a_flush_read_zero: assert property (@(posedge ref_clk) disable iff (rst)
        cfg_state && data_rd && index_q == `UFSC_IDX_P1_SHADOW && !fcr_wr[0] && !$past(fcr_wr[0])
        |=> data_rdata[`UFSC_BIT_TX_FLUSH:`UFSC_BIT_RX_FLUSH] == 2'b00)
        else $error("flush bits read back set");

    // Checker-only gap counters; they saturate so a lost tick cannot wrap to a legal count
    generate
        for (genvar k = 0; k < 2; k++) begin : g_tick_gap
            logic [DIV_W-1:0] gap_q;
            logic seen_q;
            always_ff @(posedge ref_clk or posedge rst) begin
                if (rst) begin
                    gap_q <= '0;
                    seen_q <= 1'b0;
                end else if (!misc_q[`UFSC_BIT_MUSIC_LO + k]) begin
                    gap_q <= '0;
                    seen_q <= 1'b0;
                end else if (music_baud16_tick[k]) begin
                    gap_q <= '0;
                    seen_q <= 1'b1;
                end else if (gap_q != GAP_FIRST) begin
                    gap_q <= gap_q + 1'b1;
                end
            end
            a_tick_first: assert property (@(posedge ref_clk) disable iff (rst)
                music_baud16_tick[k] && !seen_q |-> gap_q == GAP_FIRST)
                else $error("first music tick at wrong time");
            a_tick_spacing: assert property (@(posedge ref_clk) disable iff (rst)
                music_baud16_tick[k] && seen_q |-> gap_q == DIV_LAST)
                else $error("music tick spacing wrong");
            a_tick_late: assert property (@(posedge ref_clk) disable iff (rst)
                gap_q == GAP_FIRST |-> music_baud16_tick[k])
                else $error("music tick missing");
            a_tick_quiet: assert property (@(posedge ref_clk) disable iff (rst)
                !misc_q[`UFSC_BIT_MUSIC_LO + k] |=> !music_baud16_tick[k])
                else $error("music tick on a disabled port");
        end
    endgenerate

    c_misc_write: cover property (@(posedge ref_clk) disable iff (rst)
        misc_wr ##1 port3_high_speed);
    c_flush_seen: cover property (@(posedge ref_clk) disable iff (rst)
        rx_queue_flush[0] ##1 !rx_queue_flush[0]);
    c_shadow_read: cover property (@(posedge ref_clk) disable iff (rst)
        cfg_state && data_rd && index_q == `UFSC_IDX_P2_SHADOW);
    c_music_tick: cover property (@(posedge ref_clk) disable iff (rst)
        music_baud16_tick[1]);
    c_port2_flush: cover property (@(posedge ref_clk) disable iff (rst)
        rx_queue_flush[1] && tx_queue_flush[1]);
endmodule

// >>> ufsc_host_model.sv
// Host side model that drives the configuration index and data port
`timescale 1ns/100ps
module ufsc_host_model (
    input wire logic ref_clk,
    output logic cfg_state,
    output logic index_wr,
    output ufsc_pkg::ufsc_byte_t index_wdata,
    output logic data_wr,
    output logic data_rd,
    output ufsc_pkg::ufsc_byte_t data_wdata,
    input wire ufsc_pkg::ufsc_byte_t data_rdata,
    input wire logic data_hit
);
    import ufsc_pkg::*;
    initial begin
        cfg_state = 1'b1;
        index_wr = 1'b0;
        index_wdata = 8'h00;
        data_wr = 1'b0;
        data_rd = 1'b0;
        data_wdata = 8'h00;
    end
    // Leaving configuration state makes the port ignore index writes and data accesses
    task automatic set_cfg(input logic v);
        @(negedge ref_clk);
        cfg_state = v;
    endtask
    // Index is loaded before any data access
    task automatic put_index(input ufsc_byte_t idx);
        @(negedge ref_clk);
        index_wr = 1'b1;
        index_wdata = idx;
        @(negedge ref_clk);
        index_wr = 1'b0;
        index_wdata = ~idx;
    endtask
    task automatic write_data(input ufsc_byte_t v);
        data_wr = 1'b1;
        data_wdata = v;
        @(negedge ref_clk);
        data_wr = 1'b0;
        data_wdata = ~v;
    endtask
    // Answer is registered, so it is taken half a cycle after the edge
    task automatic read_data(output ufsc_byte_t d, output logic h);
        data_rd = 1'b1;
        @(negedge ref_clk);
        data_rd = 1'b0;
        d = data_rdata;
        h = data_hit;
    endtask
endmodule

// >>> uart_fifo_shadow_config_regs_test.sv
// Self-checking bench for the configuration shadow registers
`timescale 1ns/100ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin num_errors++; \
    $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, g, e); end end
module uart_fifo_shadow_config_regs_test;
    import ufsc_pkg::*;
    logic ref_clk, rst, hard_rst_pin, cfg_state, index_wr, data_wr, data_rd, data_hit;
    ufsc_byte_t index_wdata, data_wdata, data_rdata, config_index_reg, fcr_wdata;
    logic [1:0] fcr_wr, fifo_en, rx_queue_flush, tx_queue_flush, dma_mode, music_baud16_tick;
    logic [7:0] rx_threshold_bytes;
    logic port3_music_clock_sel, port4_music_clock_sel, port3_high_speed, port4_high_speed;
    int num_errors = 0;
    int n_tests = 0;
    int cycles = 0;
    ufsc_cfg_regs u_ufsc_cfg_regs (.ref_clk(ref_clk), .rst(rst), .hard_rst_pin(hard_rst_pin),
        .cfg_state(cfg_state), .index_wr(index_wr), .index_wdata(index_wdata), .data_wr(data_wr),
        .data_rd(data_rd), .data_wdata(data_wdata), .data_rdata(data_rdata), .data_hit(data_hit),
        .config_index_reg(config_index_reg), .fcr_wr(fcr_wr), .fcr_wdata(fcr_wdata), .fifo_en(fifo_en),
        .rx_queue_flush(rx_queue_flush), .tx_queue_flush(tx_queue_flush), .dma_mode(dma_mode),
        .rx_threshold_bytes(rx_threshold_bytes), .port3_music_clock_sel(port3_music_clock_sel),
        .port4_music_clock_sel(port4_music_clock_sel), .port3_high_speed(port3_high_speed),
        .port4_high_speed(port4_high_speed), .music_baud16_tick(music_baud16_tick));
    ufsc_host_model u_ufsc_host_model (.ref_clk(ref_clk), .cfg_state(cfg_state), .index_wr(index_wr),
        .index_wdata(index_wdata), .data_wr(data_wr), .data_rd(data_rd), .data_wdata(data_wdata),
        .data_rdata(data_rdata), .data_hit(data_hit));
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    task automatic report_and_stop();
        $display("comparisons=%0d mismatches=%0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Generous ceiling; the whole run needs under two thousand cycles
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            report_and_stop();
        end
    end
    task automatic rd(input ufsc_byte_t idx, output ufsc_byte_t d, output logic h);
        u_ufsc_host_model.put_index(idx);
        u_ufsc_host_model.read_data(d, h);
    endtask
    task automatic fcr(input logic [1:0] p, input ufsc_byte_t v);
        @(negedge ref_clk);
        fcr_wr = p;
        fcr_wdata = v;
        @(negedge ref_clk);
        fcr_wr = 2'b00;
        fcr_wdata = ~v;
    endtask
    task automatic t_reset();
        ufsc_byte_t d;
        logic h;
        rd(8'h17, d, h);
        `CHK(d, 8'h03)
        rd(8'h14, d, h);
        `CHK(h, 1'b1)
        rd(8'h13, d, h);
        `CHK({h, d}, 9'h000)
        rd(8'h18, d, h);
        `CHK(d, 8'h00)
        `CHK({port3_music_clock_sel, port4_music_clock_sel, port3_high_speed, port4_high_speed}, 4'h0)
        $display("t_reset done");
    endtask
    task automatic t_port1();
        ufsc_byte_t d;
        logic h;
        fcr(2'b01, 8'hFF);
        `CHK({fifo_en[0], rx_queue_flush[0], tx_queue_flush[0], dma_mode[0]}, 4'hF)
        `CHK(rx_threshold_bytes[3:0], 4'hE)
        @(negedge ref_clk);
        `CHK({rx_queue_flush[0], tx_queue_flush[0]}, 2'b00)
        u_ufsc_host_model.put_index(8'h15);
        u_ufsc_host_model.write_data(8'h00);
        rd(8'h15, d, h);
        `CHK(d, 8'hC9)
        `CHK(h, 1'b1)
        $display("t_port1 done");
    endtask
    task automatic t_port2();
        ufsc_byte_t d;
        logic h;
        logic [3:0] thr[4] = '{4'h1, 4'h4, 4'h8, 4'hE};
        for (int c = 0; c < 4; c++) begin
            fcr(2'b10, {c[1:0], 6'h09});
            `CHK(rx_threshold_bytes[7:4], thr[c])
            `CHK({fifo_en, dma_mode}, 4'hF)
            rd(8'h16, d, h);
            `CHK(d, {c[1:0], 6'h09})
        end
        fcr(2'b10, 8'h06);
        `CHK({fifo_en, rx_queue_flush[1], tx_queue_flush[1]}, 4'h7)
        @(negedge ref_clk);
        `CHK({rx_queue_flush, tx_queue_flush}, 4'h0)
        $display("t_port2 done");
    endtask
    task automatic t_misc();
        ufsc_byte_t d;
        logic h;
        int n;
        u_ufsc_host_model.set_cfg(1'b0);
        u_ufsc_host_model.put_index(8'h18);
        u_ufsc_host_model.write_data(8'hFF);
        u_ufsc_host_model.set_cfg(1'b1);
        `CHK(config_index_reg, 8'h16)
        rd(8'h18, d, h);
        `CHK(d, 8'h00)
        u_ufsc_host_model.write_data(8'hFF);
        rd(8'h18, d, h);
        `CHK(d, 8'hF0)
        `CHK({port3_music_clock_sel, port4_music_clock_sel, port3_high_speed, port4_high_speed}, 4'hF)
        n = 0;
        while (music_baud16_tick[0] !== 1'b1 && n < 400) begin
            @(negedge ref_clk);
            n++;
        end
        n = 0;
        do begin
            @(negedge ref_clk);
            n++;
        end while (music_baud16_tick[0] !== 1'b1 && n < 400);
        `CHK(n, 200)
        `CHK(music_baud16_tick, 2'b11)
        @(negedge ref_clk);
        hard_rst_pin = 1'b1;
        repeat (4) @(negedge ref_clk);
        hard_rst_pin = 1'b0;
        repeat (3) @(negedge ref_clk);
        rd(8'h18, d, h);
        `CHK(d, 8'h30)
        `CHK({port3_high_speed, port4_high_speed}, 2'b00)
        rst = 1'b1;
        @(negedge ref_clk);
        rst = 1'b0;
        rd(8'h18, d, h);
        `CHK(d, 8'h00)
        `CHK({music_baud16_tick, port3_music_clock_sel, port4_music_clock_sel}, 4'h0)
        $display("t_misc done");
    endtask
    initial begin
        rst = 1'b1;
        hard_rst_pin = 1'b0;
        fcr_wr = 2'b00;
        fcr_wdata = 8'h00;
        repeat (4) @(negedge ref_clk);
        rst = 1'b0;
        t_reset();
        t_port1();
        t_port2();
        t_misc();
        report_and_stop();
    end
endmodule
